// File: rtl/compat_decode.sv
// The strobed register port and the register addresses were chosen for this implementation.
module compat_decode #(
  parameter bit HAS_VME = 1'b1,
  parameter bit HAS_ALIGN = 1'b1,
  parameter bit HAS_QUERY = 1'b1,
  parameter bit HAS_CMPX_QUAD = 1'b1,
  parameter bit HAS_CYCLE = 1'b1,
  parameter bit HAS_MODEL_REG = 1'b1,
  parameter bit HAS_FP_CMOV = 1'b1,
  parameter logic [3:0] FAMILY = 4'h6
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic issue_valid,
  input compat_pkg::issue_type issue,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata_q,
  output logic retire_valid_q,
  output compat_pkg::retire_type retire_q,
  output logic store_valid_q,
  output logic [31:0] store_addr_q,
  output logic [31:0] store_data_q,
  output logic irq_q
);
  import compat_pkg::*;

  localparam logic [31:0] FLAGS_WMASK = flags_write_mask(HAS_VME, HAS_ALIGN, HAS_QUERY);

  logic [31:0] ctrl_q;
  logic [31:0] status_q;
  logic [31:0] status_d;
  logic [31:0] mask_q;
  logic [31:0] mask_d;
  logic [31:0] sp_q;
  logic [31:0] flags_q;
  logic [31:0] faults_q;
  logic [31:0] cycle_q;
  logic [31:0] feature_word;
  logic [31:0] family_word;
  logic executes;
  logic take;
  logic do_exec;
  logic do_fault;

  op_classify #(
    .HAS_QUERY(HAS_QUERY),
    .HAS_CMPX_QUAD(HAS_CMPX_QUAD),
    .HAS_CYCLE(HAS_CYCLE),
    .HAS_MODEL_REG(HAS_MODEL_REG),
    .HAS_FP_CMOV(HAS_FP_CMOV),
    .FAMILY(FAMILY)
  ) u_classify (
    .op(issue.op),
    .executes(executes)
  );

  // issue is ignored while software holds the run bit low
  assign take = issue_valid && ctrl_q[CTRL_RUN_BIT];
  assign do_exec = take && executes;
  assign do_fault = take && !executes;

  always_comb begin
    feature_word = 32'h0000_0000;
    // float pair on bits 0 and 15
    feature_word[FEAT_FPU_BIT] = HAS_FP_CMOV;
    feature_word[FEAT_CMOV_BIT] = HAS_FP_CMOV;
    feature_word[FEAT_CYCLE_BIT] = HAS_CYCLE;
    feature_word[FEAT_MODEL_REG_BIT] = HAS_MODEL_REG;
    feature_word[FEAT_CMPX_QUAD_BIT] = HAS_CMPX_QUAD;
    family_word = 32'h0000_0000;
    family_word[FAMILY_LSB +: 4] = FAMILY;
  end

  // retire port: one pulse per accepted instruction
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      retire_valid_q <= 1'b0;
      retire_q <= '0;
    end else begin
      retire_valid_q <= take;
      retire_q <= '0;
      if (do_fault) begin
        retire_q.fault <= 1'b1;
      end else if (do_exec && issue.op == OP_QUERY) begin
        retire_q.acc <= family_word;
        retire_q.data <= feature_word;
      end else if (do_exec && issue.op == OP_SAVE_FLAGS) begin
        retire_q.data <= flags_q;
      end else if (do_exec && issue.op == OP_RD_CYCLE) begin
        retire_q.data <= cycle_q;
      end
    end
  end

  // stack pointer and store port
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      sp_q <= SP_RESET;
      store_valid_q <= 1'b0;
      store_addr_q <= 32'h0000_0000;
      store_data_q <= 32'h0000_0000;
    end else begin
      store_valid_q <= 1'b0;
      if (do_exec && issue.op == OP_PUSH_SP) begin
        store_valid_q <= 1'b1;
        store_addr_q <= sp_q - SP_STEP;
        store_data_q <= sp_q;
        sp_q <= sp_q - SP_STEP;
      end
      // software load of the pointer overrides a push in the same cycle
      if (reg_wr && reg_addr == ADDR_SP) begin
        sp_q <= reg_wdata;
      end
    end
  end

  // status flags register
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      flags_q <= FLAGS_RESET;
    end else if (do_exec && issue.op == OP_LOAD_FLAGS) begin
      // virtual bits masked off without extensions
      flags_q <= (flags_q & ~FLAGS_WMASK) | (issue.operand & FLAGS_WMASK);
    end else if (reg_wr && reg_addr == ADDR_FLAGS) begin
      flags_q <= (flags_q & ~FLAGS_WMASK) | (reg_wdata & FLAGS_WMASK);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      cycle_q <= 32'h0000_0000;
      faults_q <= 32'h0000_0000;
    end else begin
      cycle_q <= cycle_q + 32'h0000_0001;
      if (do_fault) begin
        faults_q <= faults_q + 32'h0000_0001;
      end
    end
  end

  // sticky events: a set in the clearing cycle survives
  always_comb begin
    status_d = status_q;
    mask_d = mask_q;
    if (reg_wr && reg_addr == ADDR_STATUS) begin
      status_d = status_q & ~reg_wdata;
    end
    if (reg_wr && reg_addr == ADDR_MASK) begin
      mask_d = reg_wdata & EV_MASK;
    end
    if (do_fault) begin
      status_d[EV_FAULT_BIT] = 1'b1;
    end
    if (do_exec && issue.op == OP_QUERY) begin
      status_d[EV_QUERY_BIT] = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      status_q <= 32'h0000_0000;
      mask_q <= 32'h0000_0000;
      irq_q <= 1'b0;
    end else begin
      status_q <= status_d;
      mask_q <= mask_d;
      irq_q <= |(status_d & mask_d);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      ctrl_q <= CTRL_RESET;
    end else if (reg_wr && reg_addr == ADDR_CTRL) begin
      ctrl_q <= reg_wdata & CTRL_MASK;
    end
  end

  // read data in the cycle after the strobe, zero otherwise
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      reg_rdata_q <= 32'h0000_0000;
    end else if (!reg_rd) begin
      reg_rdata_q <= 32'h0000_0000;
    end else if (reg_addr == ADDR_CTRL) begin
      reg_rdata_q <= ctrl_q;
    end else if (reg_addr == ADDR_STATUS) begin
      reg_rdata_q <= status_q;
    end else if (reg_addr == ADDR_MASK) begin
      reg_rdata_q <= mask_q;
    end else if (reg_addr == ADDR_SP) begin
      reg_rdata_q <= sp_q;
    end else if (reg_addr == ADDR_FLAGS) begin
      reg_rdata_q <= flags_q;
    end else if (reg_addr == ADDR_FAULTS) begin
      reg_rdata_q <= faults_q;
    end else begin
      reg_rdata_q <= 32'h0000_0000;
    end
  end

  AST_RESERVED_FAULT: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (issue_valid && ctrl_q[CTRL_RUN_BIT] && issue.op > OP_TEST_REG_FROM)
    |=> (retire_valid_q && retire_q.fault && !store_valid_q && $stable(flags_q)))
    else $error("reserved code did not fault cleanly");

  AST_TEST_REG_FAULT: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (take && (issue.op == OP_TEST_REG_TO || issue.op == OP_TEST_REG_FROM))
    |=> (retire_q.fault && retire_q.data == 32'h0000_0000 && status_q[EV_FAULT_BIT]))
    else $error("test register move executed");

  AST_TEST_REG_QUIET: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (take && !reg_wr && (issue.op == OP_TEST_REG_TO || issue.op == OP_TEST_REG_FROM))
    |=> (!store_valid_q && $stable(sp_q) && $stable(flags_q)))
    else $error("test register move changed state");

  AST_QUERY_WRITABLE: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (do_exec && issue.op == OP_LOAD_FLAGS)
    |=> flags_q[FLAG_QUERY_BIT] == (HAS_QUERY && $past(issue.operand[FLAG_QUERY_BIT])))
    else $error("query permit flag not writable as expected");

  AST_VINT_POS: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (do_exec && issue.op == OP_LOAD_FLAGS)
    |=> flags_q[FLAG_VINT_BIT] == (HAS_VME && $past(issue.operand[FLAG_VINT_BIT])))
    else $error("virtual interrupt flag not at bit 19");

  AST_VPEND_POS: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (do_exec && issue.op == OP_LOAD_FLAGS)
    |=> flags_q[FLAG_VPEND_BIT] == (HAS_VME && $past(issue.operand[FLAG_VPEND_BIT])))
    else $error("virtual pending flag not at bit 20");

  AST_NO_VME_ZERO: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (!HAS_VME && reg_rd && reg_addr == ADDR_FLAGS) |=> reg_rdata_q[FLAG_VPEND_BIT:FLAG_VINT_BIT] == 2'b00)
    else $error("virtual flags readable without extensions");

  AST_NO_VME_HELD: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !HAS_VME |-> flags_q[FLAG_VPEND_BIT:FLAG_VINT_BIT] == 2'b00)
    else $error("virtual flags set without extensions");

  AST_NO_ALIGN_HELD: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !HAS_ALIGN |-> !flags_q[FLAG_ALIGN_BIT])
    else $error("alignment flag set while not implemented");

  AST_ALIGN_BIT: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (reg_wr && reg_addr == ADDR_FLAGS && !(do_exec && issue.op == OP_LOAD_FLAGS))
    |=> flags_q[FLAG_ALIGN_BIT] == (HAS_ALIGN && $past(reg_wdata[FLAG_ALIGN_BIT])))
    else $error("alignment check flag wrong");

  AST_PUSH_SP: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (do_exec && issue.op == OP_PUSH_SP)
    |=> (store_valid_q && store_data_q == $past(sp_q) && store_addr_q == $past(sp_q) - SP_STEP))
    else $error("push of stack pointer stored wrong value");

  AST_FEATURE_WORD: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (do_exec && issue.op == OP_QUERY)
    |=> (retire_q.data[FEAT_CMPX_QUAD_BIT] == HAS_CMPX_QUAD && retire_q.data[FEAT_CYCLE_BIT] == HAS_CYCLE
      && retire_q.data[FEAT_MODEL_REG_BIT] == HAS_MODEL_REG && retire_q.data[FEAT_FPU_BIT] == HAS_FP_CMOV
      && retire_q.data[FEAT_CMOV_BIT] == HAS_FP_CMOV))
    else $error("feature word mismatch");

  AST_FAMILY_PERF: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (take && issue.op == OP_RD_PERF) |=> retire_q.fault == (FAMILY != FAMILY_PERF))
    else $error("perf read presence disagrees with family");

  AST_DELIB_UNDEF: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (take && issue.op == OP_DELIB_UNDEF) |=> (retire_valid_q && retire_q.fault && !store_valid_q))
    else $error("deliberate undefined code did not fault");

  AST_UNIMPL_FAULT: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (take && ((issue.op == OP_CMPX_QUAD && !HAS_CMPX_QUAD) || (issue.op == OP_RD_CYCLE && !HAS_CYCLE)
      || ((issue.op == OP_RD_MODEL || issue.op == OP_WR_MODEL) && !HAS_MODEL_REG)
      || ((issue.op == OP_FP_CMOV || issue.op == OP_FP_CMP_FLAGS) && !HAS_FP_CMOV)))
    |=> (retire_q.fault && retire_q.data == 32'h0000_0000 && !store_valid_q && status_q[EV_FAULT_BIT]))
    else $error("unimplemented group did not fault");

endmodule : compat_decode

// File: rtl/compat_pkg.sv
package compat_pkg;

  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 8;

  // register offsets, byte addresses of aligned words
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_MASK = 8'h08;
  localparam logic [7:0] ADDR_SP = 8'h0c;
  localparam logic [7:0] ADDR_FLAGS = 8'h10;
  localparam logic [7:0] ADDR_FAULTS = 8'h14;

  localparam int unsigned CTRL_RUN_BIT = 0;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
  localparam logic [31:0] CTRL_MASK = 32'h0000_0001;

  // sticky event bits in status and mask
  localparam int unsigned EV_FAULT_BIT = 0;
  localparam int unsigned EV_QUERY_BIT = 1;
  localparam logic [31:0] EV_MASK = 32'h0000_0003;

  // status flags register layout
  localparam int unsigned FLAG_ALIGN_BIT = 18;
  localparam int unsigned FLAG_VINT_BIT = 19;
  localparam int unsigned FLAG_VPEND_BIT = 20;
  localparam int unsigned FLAG_QUERY_BIT = 21;
  localparam logic [31:0] FLAGS_BASE_MASK = 32'h0003_ffff;
  localparam logic [31:0] FLAGS_RESET = 32'h0000_0000;

  // identification result layout
  localparam int unsigned FEAT_FPU_BIT = 0;
  localparam int unsigned FEAT_CYCLE_BIT = 4;
  localparam int unsigned FEAT_MODEL_REG_BIT = 5;
  localparam int unsigned FEAT_CMPX_QUAD_BIT = 8;
  localparam int unsigned FEAT_CMOV_BIT = 15;
  localparam int unsigned FAMILY_LSB = 8;
  localparam logic [3:0] FAMILY_PERF = 4'h6;

  localparam logic [31:0] SP_STEP = 32'h0000_0004;
  localparam logic [31:0] SP_RESET = 32'h0000_0000;

  // instruction group codes on the issue port
  localparam logic [7:0] OP_NONE = 8'h00;
  localparam logic [7:0] OP_QUERY = 8'h01;
  localparam logic [7:0] OP_PUSH_SP = 8'h02;
  localparam logic [7:0] OP_LOAD_FLAGS = 8'h03;
  localparam logic [7:0] OP_SAVE_FLAGS = 8'h04;
  localparam logic [7:0] OP_CMPX_QUAD = 8'h05;
  localparam logic [7:0] OP_RD_CYCLE = 8'h06;
  localparam logic [7:0] OP_RD_MODEL = 8'h07;
  localparam logic [7:0] OP_WR_MODEL = 8'h08;
  localparam logic [7:0] OP_FP_CMOV = 8'h09;
  localparam logic [7:0] OP_FP_CMP_FLAGS = 8'h0a;
  localparam logic [7:0] OP_RD_PERF = 8'h0b;
  localparam logic [7:0] OP_DELIB_UNDEF = 8'h0c;
  localparam logic [7:0] OP_TEST_REG_TO = 8'h0d;
  localparam logic [7:0] OP_TEST_REG_FROM = 8'h0e;

  typedef struct packed {
    logic [7:0] op;
    logic [31:0] operand;
  } issue_type;

  typedef struct packed {
    logic fault;
    logic [31:0] acc;
    logic [31:0] data;
  } retire_type;

  // bits of the status flags register that a load may change
  function automatic logic [31:0] flags_write_mask(input logic vme, input logic ac, input logic qry);
    logic [31:0] m;
    m = FLAGS_BASE_MASK;
    m[FLAG_ALIGN_BIT] = ac;
    m[FLAG_VINT_BIT] = vme;
    m[FLAG_VPEND_BIT] = vme;
    m[FLAG_QUERY_BIT] = qry;
    return m;
  endfunction : flags_write_mask

endpackage : compat_pkg

// File: rtl/op_classify.sv
module op_classify #(
  parameter bit HAS_QUERY = 1'b1,
  parameter bit HAS_CMPX_QUAD = 1'b1,
  parameter bit HAS_CYCLE = 1'b1,
  parameter bit HAS_MODEL_REG = 1'b1,
  parameter bit HAS_FP_CMOV = 1'b1,
  parameter logic [3:0] FAMILY = 4'h6
) (
  input wire logic [7:0] op,
  output logic executes
);
  import compat_pkg::*;

  always_comb begin
    executes = 1'b0;
    if (op == OP_NONE || op == OP_PUSH_SP || op == OP_LOAD_FLAGS || op == OP_SAVE_FLAGS) begin
      executes = 1'b1;
    end else if (op == OP_QUERY) begin
      executes = HAS_QUERY;
    end else if (op == OP_CMPX_QUAD) begin
      executes = HAS_CMPX_QUAD;
    end else if (op == OP_RD_CYCLE) begin
      executes = HAS_CYCLE;
    end else if (op == OP_RD_MODEL || op == OP_WR_MODEL) begin
      executes = HAS_MODEL_REG;
    end else if (op == OP_FP_CMOV || op == OP_FP_CMP_FLAGS) begin
      executes = HAS_FP_CMOV;
    end else if (op == OP_RD_PERF) begin
      executes = (FAMILY == FAMILY_PERF);
    end else if (op == OP_TEST_REG_TO || op == OP_TEST_REG_FROM) begin
      executes = 1'b0;
    end else begin
      executes = 1'b0;
    end
  end

endmodule : op_classify

// File: verif/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import compat_pkg::*;

  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic issue_valid = 1'b0;
  issue_type issue = '0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata_q;
  logic retire_valid_q;
  retire_type retire_q;
  logic [31:0] lean_rdata_q;
  retire_type lean_retire_q;
  logic store_valid_q;
  logic [31:0] store_addr_q;
  logic [31:0] store_data_q;
  logic irq_q;
  int error_cnt = 0;
  int n_compared = 0;
  int cyc = 0;

  compat_decode u_compat_decode (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .issue_valid(issue_valid),
    .issue(issue),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata_q(reg_rdata_q),
    .retire_valid_q(retire_valid_q),
    .retire_q(retire_q),
    .store_valid_q(store_valid_q),
    .store_addr_q(store_addr_q),
    .store_data_q(store_data_q),
    .irq_q(irq_q)
  );

  // second build with the optional groups and flags other than query left out, same stimulus
  compat_decode #(
    .HAS_VME(1'b0),
    .HAS_ALIGN(1'b0),
    .HAS_QUERY(1'b1),
    .HAS_CMPX_QUAD(1'b0),
    .HAS_CYCLE(1'b0),
    .HAS_MODEL_REG(1'b0),
    .HAS_FP_CMOV(1'b0),
    .FAMILY(4'h5)
  ) u_compat_decode_lean (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .issue_valid(issue_valid),
    .issue(issue),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata_q(lean_rdata_q),
    .retire_valid_q(),
    .retire_q(lean_retire_q),
    .store_valid_q(),
    .store_addr_q(),
    .store_data_q(),
    .irq_q()
  );

  always #5 clk_sys = ~clk_sys;

  task automatic end_of_test();
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_of_test

  // whole run needs well under a thousand cycles
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      end_of_test();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // outputs are sampled 1 ns after the edge that takes the request
  task automatic op(input logic [7:0] code, input logic [31:0] arg);
    @(posedge clk_sys);
    issue_valid <= 1'b1;
    issue <= '{op: code, operand: arg};
    @(posedge clk_sys);
    issue_valid <= 1'b0;
    #1;
  endtask : op

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata_q;
  endtask : rd

  initial begin
    static logic [7:0] ra [6] = '{ADDR_CTRL, ADDR_STATUS, ADDR_MASK, ADDR_SP, ADDR_FLAGS, ADDR_FAULTS};
    static logic [31:0] rv [6] = '{32'h0000_0001, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
    static logic [7:0] bad [5] = '{8'h0c, 8'h0d, 8'h0e, 8'h0f, 8'hff};
    logic [31:0] v;
    repeat (20) @(posedge clk_sys);
    rst_b <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      rd(ra[i], v);
      check(v, rv[i]);
    end
    rd(8'h40, v);
    check(v, 32'h0);

    op(OP_QUERY, 32'h0);
    check(retire_valid_q, 1'b1);
    check(retire_q.fault, 1'b0);
    check(retire_q.acc[11:8], 4'h6);
    check(retire_q.data[8], 1'b1);
    check(retire_q.data[4], 1'b1);
    check(retire_q.data[5], 1'b1);
    check({retire_q.data[15], retire_q.data[0]}, 2'b11);
    check(lean_retire_q.data, 32'h0000_0000);
    check(lean_retire_q.acc[11:8], 4'h5);
    rd(ADDR_STATUS, v);
    check(v[1], 1'b1);

    // new flags must take both values through load and bus
    op(OP_LOAD_FLAGS, 32'hffff_ffff);
    op(OP_SAVE_FLAGS, 32'h0);
    check(retire_q.data[21], 1'b1);
    check(retire_q.data[20], 1'b1);
    check(retire_q.data[19], 1'b1);
    check(retire_q.data[18], 1'b1);
    check(retire_q.data[31:22], 10'h000);
    check(lean_retire_q.data, 32'h0023_ffff);
    check(lean_retire_q.data[18], 1'b0);
    op(OP_LOAD_FLAGS, 32'h0);
    op(OP_SAVE_FLAGS, 32'hffff_ffff);
    check(retire_q.data, 32'h0000_0000);
    wr(ADDR_FLAGS, 32'h0028_0000);
    rd(ADDR_FLAGS, v);
    check(v, 32'h0028_0000);
    check(lean_rdata_q, 32'h0020_0000);
    wr(ADDR_FLAGS, 32'h0014_0000);
    rd(ADDR_FLAGS, v);
    check(v, 32'h0014_0000);
    check(lean_rdata_q, 32'h0000_0000);

    // two successive pushes, one idle cycle apart, store the value before each decrement
    wr(ADDR_SP, 32'h0000_0100);
    op(OP_PUSH_SP, 32'h0);
    check(store_valid_q, 1'b1);
    check(store_addr_q, 32'h0000_00fc);
    check(store_data_q, 32'h0000_0100);
    op(OP_PUSH_SP, 32'h0);
    check(store_data_q, 32'h0000_00fc);
    rd(ADDR_SP, v);
    check(v, 32'h0000_00f8);

    wr(ADDR_MASK, 32'h0000_0001);
    wr(ADDR_STATUS, 32'h0000_0003);
    wr(ADDR_FLAGS, 32'h0000_0055);
    check(irq_q, 1'b0);
    for (int i = 0; i < 5; i++) begin
      op(bad[i], 32'hffff_ffff);
      check(retire_q.fault, 1'b1);
      check(retire_q.acc, 32'h0);
      check(retire_q.data, 32'h0);
      check(store_valid_q, 1'b0);
    end
    rd(ADDR_FLAGS, v);
    check(v, 32'h0000_0055);
    rd(ADDR_SP, v);
    check(v, 32'h0000_00f8);
    rd(ADDR_FAULTS, v);
    check(v, 32'h0000_0005);
    check(irq_q, 1'b1);
    wr(ADDR_STATUS, 32'h0000_0001);
    rd(ADDR_STATUS, v);
    check(v[0], 1'b0);
    check(irq_q, 1'b0);
    wr(ADDR_MASK, 32'h0000_0000);
    op(8'h0f, 32'h0);
    rd(ADDR_STATUS, v);
    check(v[0], 1'b1);
    check(irq_q, 1'b0);

    // every optional group except query, codes 5 to 11, retires without a fault in the full build and faults in the lean one
    for (int c = 5; c <= 11; c++) begin
      op(8'(c), 32'h0);
      check(retire_valid_q, 1'b1);
      check(retire_q.fault, 1'b0);
      check(lean_retire_q.fault, 1'b1);
    end

    wr(ADDR_CTRL, 32'h0000_0000);
    op(OP_QUERY, 32'h0);
    check(retire_valid_q, 1'b0);
    wr(ADDR_CTRL, 32'h0000_0001);
    op(OP_RD_PERF, 32'h0);
    check(retire_q.fault, 1'b0);
    check(lean_retire_q.fault, 1'b1);
    end_of_test();
  end
endmodule : tb_top
